// ---- src/adc_data_ready_serial_port.sv ----
// data-ready signalling, serial register routing and update timing
// assumes sclk, din and cs_n are asynchronous pins; conv_word and the
// AXI4-Lite master run on clk
//
// Added by the designer: the address map and the AXI4-Lite register port.
`include "adc_port_regs.svh"
module adc_data_ready_serial_port #(
  parameter int unsigned UPD_DIV = 1,
  parameter int unsigned CAL_CYC = `CAL_CYC
) (
  // clock and reset
  input  logic        clk,
  input  logic        arst_n,
  // serial pins
  input  logic        sclk,
  input  logic        din,
  input  logic        cs_n,
  output logic        dout,
  output logic        dout_oe,
  output logic        result_ready_n,
  // conversion result from the filter
  input  logic [15:0] conv_word,
  // AXI4-Lite write
  input  logic [3:0]  awaddr,
  input  logic        awvalid,
  output logic        awready,
  input  logic [31:0] wdata,
  input  logic [3:0]  wstrb,
  input  logic        wvalid,
  output logic        wready,
  output logic [1:0]  bresp,
  output logic        bvalid,
  input  logic        bready,
  // AXI4-Lite read
  input  logic [3:0]  araddr,
  input  logic        arvalid,
  output logic        arready,
  output logic [31:0] rdata,
  output logic [1:0]  rresp,
  output logic        rvalid,
  input  logic        rready,
  // interrupt
  output logic        irq
);
  localparam int unsigned HI_HZ [4] =
    '{`RATE_H0, `RATE_H1, `RATE_H2, `RATE_H3};
  localparam int unsigned LO_HZ [4] =
    '{`RATE_L0, `RATE_L1, `RATE_L2, `RATE_L3};

  logic [7:0]  byte_rx;
  logic        byte_valid;
  logic        load;
  logic [15:0] load_word;

  adc_port_pkg::port_state_t state_q;
  logic [7:0]  comm_q;
  logic [7:0]  setup_q;
  logic [7:0]  clock_q;
  logic [15:0] data_q;
  logic        rdy_n_q;
  logic        cal_q;
  logic [20:0] cal_cnt_q;
  logic [20:0] upd_cnt_q;

  logic [2:0]  rs_new;
  logic [2:0]  rs_sel;
  logic        comm_take;
  logic        wr_byte;
  logic        word_done;
  logic        clk_wr;
  logic        cal_go;
  logic        cal_end;
  logic        run;
  logic        upd_now;

  logic [`IRQ_W-1:0] stat_q;
  logic [`IRQ_W-1:0] mask_q;
  logic [`IRQ_W-1:0] ev;
  logic [`IRQ_W-1:0] clr;

  logic        aw_q;
  logic        w_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_wr;

  // update period in clk cycles, less one, for a clock register value
  function automatic logic [20:0] period_of(input logic [7:0] ck);
    logic [1:0]  sel;
    int unsigned hz;
    int unsigned cyc;
    sel = {ck[`RATE_SELECT_HIGH_BIT], ck[`RATE_SELECT_LOW_BIT]};
    hz  = ck[`CLK_FAST] ? HI_HZ[sel] : LO_HZ[sel];
    cyc = `CLK_HZ / (hz * UPD_DIV);
    if (ck[`MASTER_CLOCK_HALVE_BIT]) begin
      cyc = cyc * 2;
    end
    return 21'(cyc - 1);
  endfunction

  // reset period, worked out once so the reset branch loads a constant
  localparam logic [20:0] RST_PERIOD = period_of(`BYTE_RST);

  serial_shifter u_shift (
    .clk        (clk),
    .arst_n     (arst_n),
    .sclk       (sclk),
    .din        (din),
    .cs_n       (cs_n),
    .dout       (dout),
    .dout_oe    (dout_oe),
    .byte_rx    (byte_rx),
    .byte_valid (byte_valid),
    .load       (load),
    .load_word  (load_word)
  );

  assign rs_new = {byte_rx[`REGISTER_SELECT_BIT2],
                   byte_rx[`REGISTER_SELECT_BIT1],
                   byte_rx[`REGISTER_SELECT_BIT0]};
  assign rs_sel = {comm_q[`REGISTER_SELECT_BIT2],
                   comm_q[`REGISTER_SELECT_BIT1],
                   comm_q[`REGISTER_SELECT_BIT0]};

  // a byte with the enable bit high is ignored while awaiting a command
  assign comm_take = byte_valid && !byte_rx[`COMM_WEN] &&
                     state_q == adc_port_pkg::st_comm;
  assign load      = comm_take && byte_rx[`COMM_RW];
  assign wr_byte   = byte_valid && state_q == adc_port_pkg::st_write;
  assign word_done = byte_valid && state_q == adc_port_pkg::st_read_lo;
  assign clk_wr    = wr_byte && rs_sel == `RS_CLOCK;
  assign cal_go    = wr_byte && rs_sel == `RS_SETUP &&
                     byte_rx[`SETUP_MD] != `MD_NORMAL;
  assign cal_end   = cal_q && cal_cnt_q == '0 && !cal_go;
  assign run       = !comm_q[`COMM_STBY] && !cal_q;
  assign upd_now   = run && !clk_wr && upd_cnt_q == '0;

  // output shifter source; 8-bit registers sit in the upper byte
  always_comb begin
    case (rs_new)
      `RS_COMM:  load_word = {rdy_n_q, byte_rx[`COMM_LOW], `BYTE_RST};
      `RS_SETUP: load_word = {setup_q, `BYTE_RST};
      `RS_CLOCK: load_word = {clock_q, `BYTE_RST};
      `RS_DATA:  load_word = data_q;
      default:   load_word = `WORD_RST;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= adc_port_pkg::st_comm;
    end else if (byte_valid) begin
      unique case (state_q)
        adc_port_pkg::st_comm: begin
          if (!byte_rx[`COMM_WEN]) begin
            if (!byte_rx[`COMM_RW]) begin
              state_q <= adc_port_pkg::st_write;
            end else if (rs_new == `RS_DATA) begin
              state_q <= adc_port_pkg::st_read_hi;
            end else begin
              state_q <= adc_port_pkg::st_read8;
            end
          end
        end
        adc_port_pkg::st_read_hi: begin
          state_q <= adc_port_pkg::st_read_lo;
        end
        default: begin
          state_q <= adc_port_pkg::st_comm;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      comm_q <= `BYTE_RST;
    end else if (comm_take) begin
      comm_q <= byte_rx;
    end else if (wr_byte && rs_sel == `RS_COMM) begin
      comm_q <= byte_rx;
    end
  end

  // a write that starts calibration beats the end of a running one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      setup_q <= `BYTE_RST;
    end else if (wr_byte && rs_sel == `RS_SETUP) begin
      setup_q <= byte_rx;
    end else if (cal_end) begin
      setup_q[`SETUP_MD] <= `MD_NORMAL;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clock_q <= `BYTE_RST;
    end else if (clk_wr) begin
      clock_q <= byte_rx;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_q     <= 1'b0;
      cal_cnt_q <= '0;
    end else if (cal_go) begin
      cal_q     <= 1'b1;
      cal_cnt_q <= 21'(CAL_CYC - 1);
    end else if (cal_end) begin
      cal_q <= 1'b0;
    end else if (cal_q) begin
      cal_cnt_q <= cal_cnt_q - 21'h1;
    end
  end

  // the filter restarts on a rate change and after calibration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      upd_cnt_q <= RST_PERIOD;
    end else if (clk_wr) begin
      upd_cnt_q <= period_of(byte_rx);
    end else if (cal_q) begin
      upd_cnt_q <= period_of(clock_q);
    end else if (upd_now) begin
      upd_cnt_q <= period_of(clock_q);
    end else if (run) begin
      upd_cnt_q <= upd_cnt_q - 21'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_q <= `WORD_RST;
    end else if (upd_now) begin
      data_q <= conv_word;
    end
  end

  // the word in flight was copied into the shifter at read start, so an
  // update during a late read cannot tear it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdy_n_q <= 1'b1;
    end else if (upd_now) begin
      rdy_n_q <= 1'b0;
    end else if (cal_end) begin
      rdy_n_q <= 1'b0;
    end else if (word_done || cal_go) begin
      rdy_n_q <= 1'b1;
    end else if (run && upd_cnt_q == `PRE_UPD_CYC) begin
      rdy_n_q <= 1'b1;
    end
  end

  assign result_ready_n = rdy_n_q;

  // interrupt status: events win over a clear in the same cycle
  always_comb begin
    ev = '0;
    ev[`IRQ_UPD] = upd_now;
    ev[`IRQ_CAL] = cal_end;
    ev[`IRQ_RD]  = word_done;
  end

  assign clr = (do_wr && awaddr_q == `A_STAT && wstrb_q[0]) ?
               wdata_q[`IRQ_W-1:0] : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr) | ev;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= '0;
    end else if (do_wr && awaddr_q == `A_MASK && wstrb_q[0]) begin
      mask_q <= wdata_q[`IRQ_W-1:0];
    end
  end

  assign irq = |(stat_q & mask_q);

  // AXI4-Lite write: address and data taken in either order
  assign awready = !aw_q && !bvalid;
  assign wready  = !w_q && !bvalid;
  assign do_wr   = aw_q && w_q && !bvalid;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_q     <= 1'b0;
      awaddr_q <= '0;
    end else if (awvalid && awready) begin
      aw_q     <= 1'b1;
      awaddr_q <= awaddr;
    end else if (do_wr) begin
      aw_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      w_q     <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wvalid && wready) begin
      w_q     <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (do_wr) begin
      w_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OK;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      case (awaddr_q)
        `A_STAT, `A_MASK, `A_STATE, `A_DATA: bresp <= `RESP_OK;
        default: bresp <= `RESP_ERR;
      endcase
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read
  assign arready = !rvalid;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= `RESP_OK;
      case (araddr)
        `A_STAT:  rdata <= 32'(stat_q);
        `A_MASK:  rdata <= 32'(mask_q);
        `A_STATE: rdata <= {comm_q, setup_q, clock_q, 3'h0,
                            state_q, cal_q, rdy_n_q};
        `A_DATA:  rdata <= {`WORD_RST, data_q};
        default: begin
          rdata <= '0;
          rresp <= `RESP_ERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// ---- src/adc_port_regs.svh ----
// constants for the converter serial port and data-ready block
// assumes a 10 MHz master clock and an AXI4-Lite register bus
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

`define CLK_HZ       10000000
`define RATE_H0      50
`define RATE_H1      60
`define RATE_H2      250
`define RATE_H3      500
`define RATE_L0      20
`define RATE_L1      25
`define RATE_L2      100
`define RATE_L3      200
`define PRE_UPD_CYC  21'd500
`define CAL_CYC      1000

`define RS_COMM      3'h0
`define RS_SETUP     3'h1
`define RS_CLOCK     3'h2
`define RS_DATA      3'h3

`define COMM_WEN     7
`define REGISTER_SELECT_BIT2 6
`define REGISTER_SELECT_BIT1 5
`define REGISTER_SELECT_BIT0 4
`define COMM_RW      3
`define COMM_STBY    2
`define COMM_LOW     6:0
`define SETUP_MD     7:6
`define MD_NORMAL    2'h0
`define MASTER_CLOCK_HALVE_BIT 3
`define CLK_FAST     2
`define RATE_SELECT_HIGH_BIT 1
`define RATE_SELECT_LOW_BIT  0

`define BYTE_RST     8'h00
`define WORD_RST     16'h0000
`define BIT_LAST     3'h7

`define A_STAT       4'h0
`define A_MASK       4'h4
`define A_STATE      4'h8
`define A_DATA       4'hc
`define IRQ_W        3
`define IRQ_UPD      0
`define IRQ_CAL      1
`define IRQ_RD       2
`define RESP_OK      2'h0
`define RESP_ERR     2'h2

`endif

// ---- src/adc_port_pkg.sv ----
// types shared by the serial port logic
// assumes nothing beyond a SystemVerilog tool
package adc_port_pkg;
  typedef enum logic [2:0] {
    st_comm    = 3'b000,
    st_write   = 3'b001,
    st_read8   = 3'b010,
    st_read_hi = 3'b011,
    st_read_lo = 3'b100
  } port_state_t;
endpackage

// ---- src/serial_shifter.sv ----
// serial pin front end: synchronisers, input and output shifters
// assumes sclk idles high, host drives din on falling and samples
// dout on rising edges, and sclk half periods span at least 4 clk
`include "adc_port_regs.svh"
module serial_shifter (
  // clock and reset
  input  logic        clk,
  input  logic        arst_n,
  // pins
  input  logic        sclk,
  input  logic        din,
  input  logic        cs_n,
  output logic        dout,
  output logic        dout_oe,
  // byte side
  output logic [7:0]  byte_rx,
  output logic        byte_valid,
  input  logic        load,
  input  logic [15:0] load_word
);
  logic        sclk_s1, sclk_s2, sclk_s3;
  logic        din_s1, din_s2;
  logic        cs_s1, cs_s2;
  logic [6:0]  sh_in_q;
  logic [2:0]  bit_q;
  logic [15:0] sh_out_q;
  logic        fresh_q;
  logic        rise, fall;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
      din_s1  <= 1'b0;
      din_s2  <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
    end else begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      din_s1  <= din;
      din_s2  <= din_s1;
      cs_s1   <= cs_n;
      cs_s2   <= cs_s1;
    end
  end

  assign rise    = sclk_s2 && !sclk_s3;
  assign fall    = !sclk_s2 && sclk_s3;
  assign dout    = sh_out_q[15];
  assign dout_oe = !cs_s2;

  // a deselected port drops a partial byte but keeps the access state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_q      <= '0;
      sh_in_q    <= '0;
      byte_rx    <= `BYTE_RST;
      byte_valid <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      if (cs_s2) begin
        bit_q <= '0;
      end else if (rise) begin
        sh_in_q <= {sh_in_q[5:0], din_s2};
        bit_q   <= bit_q + 3'h1;
        if (bit_q == `BIT_LAST) begin
          byte_rx    <= {sh_in_q, din_s2};
          byte_valid <= 1'b1;
        end
      end
    end
  end

  // the first falling edge after a load opens the byte, so it must
  // not shift, or the msb would be lost before the host samples it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_out_q <= `WORD_RST;
      fresh_q  <= 1'b0;
    end else if (load) begin
      sh_out_q <= load_word;
      fresh_q  <= 1'b1;
    end else if (fall && !cs_s2) begin
      if (fresh_q) begin
        fresh_q <= 1'b0;
      end else begin
        sh_out_q <= {sh_out_q[14:0], 1'b0};
      end
    end
  end
endmodule

// ---- test/adc_port_checker.sv ----
// assertions on the top ports of the data-ready serial port block
// assumes one clock and an async active-low reset
module adc_port_checker (
  // clock and reset
  input logic        clk,
  input logic        arst_n,
  // serial and data-ready
  input logic        cs_n,
  input logic        dout_oe,
  input logic        result_ready_n,
  // register bus
  input logic        awvalid,
  input logic        awready,
  input logic        wvalid,
  input logic        wready,
  input logic [1:0]  bresp,
  input logic        bvalid,
  input logic        bready,
  input logic        arvalid,
  input logic        arready,
  input logic [31:0] rdata,
  input logic        rvalid,
  input logic        rready,
  input logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // gap_q: a rise with the port idle, so no read caused it
  logic [13:0] hi_cnt_q;
  logic        gap_q;
  logic        rdy_q;
  // rdy_q resets to the idle level so no false rise follows reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt_q <= 14'h0;
      gap_q    <= 1'h0;
      rdy_q    <= 1'h1;
    end else begin
      hi_cnt_q <= result_ready_n ? hi_cnt_q + 14'h1 : 14'h0;
      rdy_q    <= result_ready_n;
      gap_q    <= cs_n && result_ready_n && (!rdy_q || gap_q);
    end
  end
  a_gap_exact:
    assert property (gap_q && $fell(result_ready_n) |-> hi_cnt_q == 14'h1f4)
    else $error("ready gap wrong");
  a_oe_off:
    assert property (cs_n [*4] |-> !dout_oe) else $error("oe while idle");
  a_oe_on:
    assert property (!cs_n [*4] |-> dout_oe) else $error("oe missing");
  a_b_hold:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("b dropped");
  a_r_hold:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("r dropped");
  a_ar_block:
    assert property (rvalid |-> !arready) else $error("ar taken");
  a_wr_refused:
    assert property (bvalid |-> !awready && !wready) else $error("aw taken");
  a_b_latency:
    assert property (awvalid && awready && wvalid && wready
      |=> !bvalid ##1 bvalid) else $error("b late");
  a_r_latency:
    assert property (arvalid && arready |=> rvalid) else $error("r late");
  cover property (gap_q && $fell(result_ready_n));
  cover property ($rose(irq));
  cover property (bvalid && bready && bresp == 2'h2);
endmodule

bind adc_data_ready_serial_port adc_port_checker i_adc_port_checker (.*);

// ---- test/host_serial_model.sv ----
// host side of the serial link: drives sclk, din and cs_n
// assumes sclk idles high and dout is settled at each sclk rise
module host_serial_model (
  // clock
  input  wire logic clk,
  // serial pins
  input  wire logic dout,
  output logic      sclk,
  output logic      din,
  output logic      cs_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'h1;
    din  = 1'h0;
    cs_n = 1'h1;
  end
  // callers open every access with a communication byte
  task automatic xfer(input logic [23:0] tx, input int n,
                      output logic [23:0] rx);
    rx = 24'h0;
    @(posedge clk);
    cs_n <= 1'h0;
    repeat (3) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'h0;
      din  <= tx[i];
      repeat (5) @(posedge clk);
      sclk <= 1'h1;
      rx = {rx[22:0], dout};
      repeat (5) @(posedge clk);
    end
    // din has no pull: show a changed level once released
    cs_n <= 1'h1;
    din  <= ~tx[0];
  endtask
endmodule

// ---- test/adc_data_ready_serial_port_tb.sv ----
// self-checking bench for the data-ready serial port block
// assumes host_serial_model on the pins and update divider of 100
module adc_data_ready_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0;
  logic        arst_n = 1'h0;
  logic        sclk, din, cs_n, dout, dout_oe, result_ready_n, irq;
  logic [15:0] conv_word = 16'h1234;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [23:0] rx;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          n1, n2;

  always #50 clk = ~clk;

  adc_data_ready_serial_port #(.UPD_DIV(100), .CAL_CYC(20))
    i_adc_data_ready_serial_port (.*);
  host_serial_model host (.*);

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wait_rdy(input logic v, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (result_ready_n !== v);
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic ad, wd, bd;
    ad = 1'h0;
    wd = 1'h0;
    bd = 1'h0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!bd) begin
      @(negedge clk);
      ad = ad | (awvalid & awready);
      wd = wd | (wvalid & wready);
      bd = bvalid;
      r  = bresp;
      @(posedge clk);
      if (ad) awvalid <= 1'h0;
      if (wd) wvalid <= 1'h0;
      if (bd) bready <= 1'h0;
    end
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ad, dd;
    ad = 1'h0;
    dd = 1'h0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    while (!dd) begin
      @(negedge clk);
      ad = ad | (arvalid & arready);
      dd = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clk);
      if (ad) arvalid <= 1'h0;
      if (dd) rready <= 1'h0;
    end
  endtask

  task automatic t_rates;
    logic [7:0] cfg [3] = '{8'h00, 8'h04, 8'h09};
    int         per [3] = '{5000, 2000, 8000};
    foreach (cfg[i]) begin
      host.xfer({8'h20, cfg[i]}, 16, rx);
      host.xfer({8'h28, 8'h00}, 16, rx);
      chk("clock_reg", rx[7:0], cfg[i]);
      axi_rd(4'h8, rd, rs);
      chk("state_clock", rd[15:8], cfg[i]);
      wait_rdy(1'h1, n1);
      wait_rdy(1'h0, n1);
      wait_rdy(1'h1, n1);
      wait_rdy(1'h0, n2);
      chk("pre_update_gap", n2, 500);
      chk("period", n1 + n2, per[i]);
    end
    $display("rate test done");
  endtask

  task automatic t_read;
    @(posedge clk) conv_word <= 16'hc3a5;
    wait_rdy(1'h1, n1);
    wait_rdy(1'h0, n1);
    host.xfer({8'h38, 16'h0000}, 24, rx);
    chk("data_word", rx[15:0], 16'hc3a5);
    @(negedge clk);
    chk("ready_after_read", result_ready_n, 1'h1);
    host.xfer({8'h08, 8'h00}, 16, rx);
    chk("comm_reg", rx[7:0], 8'h88);
    axi_rd(4'hc, rd, rs);
    chk("data_reg", rd, 32'h0000c3a5);
    $display("read test done");
  endtask

  task automatic t_cal;
    host.xfer({8'h10, 8'h40}, 16, rx);
    @(negedge clk);
    chk("cal_busy", result_ready_n, 1'h1);
    wait_rdy(1'h0, n1);
    chk("cal_len", n1 > 5 && n1 < 30, 1'h1);
    axi_rd(4'h8, rd, rs);
    chk("setup_mode", rd[23:22], 2'h0);
    $display("calibration test done");
  endtask

  task automatic t_irq;
    axi_rd(4'h0, rd, rs);
    chk("status", rd[2:0], 3'h7);
    chk("irq_masked", irq, 1'h0);
    axi_wr(4'h4, 32'h2, rs);
    @(negedge clk);
    chk("irq_on", irq, 1'h1);
    axi_wr(4'h0, 32'h2, rs);
    @(negedge clk);
    chk("irq_off", irq, 1'h0);
    axi_rd(4'h2, rd, rs);
    chk("unmapped", rs, 2'h2);
    axi_wr(4'h8, 32'hff, rs);
    chk("ro_write", rs, 2'h0);
    axi_wr(4'h6, 32'h1, rs);
    chk("unmapped_wr", rs, 2'h2);
    $display("interrupt test done");
  endtask

  task automatic t_reset;
    @(posedge clk);
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("irq_reset", irq, 1'h0);
    axi_rd(4'h8, rd, rs);
    chk("state_reset", rd, 32'h00000001);
    axi_rd(4'hc, rd, rs);
    chk("data_reset", rd, 32'h00000000);
    axi_rd(4'h0, rd, rs);
    chk("status_reset", rd, 32'h00000000);
    $display("reset test done");
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("ready_reset", result_ready_n, 1'h1);
    chk("oe_reset", dout_oe, 1'h0);
    t_rates;
    t_read;
    t_cal;
    t_irq;
    t_reset;
    end_sim;
  end

  // the tests need about 40000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    end_sim;
  end
endmodule
